// ---- hw/boundary_scan_test_mode.sv ----
`timescale 1ns/1ps
`include "scan_map.svh"
module boundary_scan_test_mode
   import scan_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [66:0] pad_levels,
   input wire logic scan_mode_enable,
   input wire logic scan_shift_select,
   input wire logic scan_clock,
   input wire logic scan_output_enable_n,
   input wire logic mirror_function_pin,
   input wire logic core_strobe_out,
   input wire logic core_strobe_oe_n,
   input wire logic write_strobe_lane0_in,
   output logic write_strobe_lane0_out,
   output logic write_strobe_lane0_oe_n,
   output logic core_strobe_in,
   output logic mirror_active,
   output logic ca_term_nominal,
   output logic dq_term_on,
   output logic scan_active
);
   localparam int SW = `SCAN_SYNC_W;

   // Pin synchroniser: three stages, level taken when stages two and three agree
   logic [SW-1:0] raw_in;
   logic [SW-1:0] s1_ff, s2_ff, s3_ff, lvl_ff, nxt_lvl;
   assign raw_in = {pad_levels, mirror_function_pin, scan_output_enable_n, scan_clock,
                    scan_shift_select, scan_mode_enable};

   always_comb begin
      nxt_lvl = (s2_ff & s3_ff) | (lvl_ff & (s2_ff | s3_ff));
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s1_ff <= '0;
         s2_ff <= '0;
         s3_ff <= '0;
         lvl_ff <= '0;
      end else begin
         s1_ff <= raw_in;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         lvl_ff <= nxt_lvl;
      end
   end

   logic sen_lvl, ssh_lvl, sck_lvl, soe_n_lvl, mf_lvl;
   chain_t pad_lvl;
   assign sen_lvl = lvl_ff[`SCAN_IN_SEN];
   assign ssh_lvl = lvl_ff[`SCAN_IN_SSH];
   assign sck_lvl = lvl_ff[`SCAN_IN_SCK];
   assign soe_n_lvl = lvl_ff[`SCAN_IN_SOE];
   assign mf_lvl = lvl_ff[`SCAN_IN_MF];
   assign pad_lvl = lvl_ff[SW-1:`SCAN_IN_PAD];

   // Capture image with reserved balls forced low
   function automatic chain_t capture_image(input chain_t pads);
      chain_t img;
      img = pads;
      img[`SCAN_RSV_IDX_A] = 1'b0;
      img[`SCAN_RSV_IDX_B] = 1'b0;
      return img;
   endfunction

   scan_stream_if #(.WIDTH(`SCAN_FIFO_WIDTH)) st ();

   scan_fifo #(.WIDTH(`SCAN_FIFO_WIDTH), .DEPTH(`SCAN_FIFO_DEPTH)) u_fifo (
      .clk(clk),
      .reset_n(reset_n),
      .st(st)
   );

   // Mode, edge pending and chain state
   mode_t mode_ff, nxt_mode;
   logic sck_prev_ff, nxt_sck_prev;
   logic pend_ff, nxt_pend;
   scan_op_t op_ff, nxt_op;
   chain_t chain_ff, nxt_chain;
   logic sck_rise, in_scan, push_fire, pop_fire;

   assign in_scan = (mode_ff == st_scan);
   assign sck_rise = sck_lvl && !sck_prev_ff;
   assign push_fire = st.push_valid && st.push_ready;
   assign pop_fire = st.pop_valid && st.pop_ready;
   assign st.flush = !in_scan;
   assign st.push_valid = pend_ff && in_scan;
   assign st.push_data = nxt_chain[0];
   assign st.pop_ready = in_scan && !soe_n_lvl;

   always_comb begin
      nxt_mode = mode_ff;
      nxt_sck_prev = sck_lvl;
      nxt_pend = pend_ff;
      nxt_op = op_ff;
      nxt_chain = chain_ff;
      case (mode_ff)
         st_normal: begin
            nxt_pend = 1'b0;
            if (sen_lvl) nxt_mode = st_scan;
         end
         st_scan: begin
            if (pend_ff) begin
               if (op_ff == op_capture) begin
                  nxt_chain = capture_image(pad_lvl);
               end else begin
                  nxt_chain = {1'b0, chain_ff[66:1]};
               end
            end
            if (push_fire) nxt_pend = 1'b0;
            // A new edge wins over the retiring one
            if (sck_rise) begin
               nxt_pend = 1'b1;
               nxt_op = ssh_lvl ? op_shift : op_capture;
            end
            if (!push_fire) nxt_chain = chain_ff;
            if (!sen_lvl) begin
               nxt_mode = st_normal;
               nxt_pend = 1'b0;
            end
         end
         default: nxt_mode = st_normal;
      endcase
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         mode_ff <= st_normal;
         sck_prev_ff <= 1'b0;
         pend_ff <= 1'b0;
         op_ff <= op_capture;
         chain_ff <= '0;
      end else begin
         mode_ff <= nxt_mode;
         sck_prev_ff <= nxt_sck_prev;
         pend_ff <= nxt_pend;
         op_ff <= nxt_op;
         chain_ff <= nxt_chain;
      end
   end

   // Pin and side-band outputs, all registered
   logic nxt_pin_out, nxt_pin_oe_n, nxt_core_in, nxt_mirror, nxt_ca_term, nxt_dq_term;
   logic nxt_active;

   always_comb begin
      nxt_core_in = write_strobe_lane0_in;
      nxt_mirror = !in_scan && mf_lvl;
      nxt_ca_term = in_scan;
      nxt_dq_term = !in_scan;
      nxt_active = in_scan;
      if (in_scan) begin
         nxt_pin_out = pop_fire ? st.pop_data[0] : write_strobe_lane0_out;
         nxt_pin_oe_n = soe_n_lvl;
      end else begin
         nxt_pin_out = core_strobe_out;
         nxt_pin_oe_n = core_strobe_oe_n;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         write_strobe_lane0_out <= 1'b0;
         write_strobe_lane0_oe_n <= 1'b1;
         core_strobe_in <= 1'b0;
         mirror_active <= 1'b0;
         ca_term_nominal <= 1'b0;
         dq_term_on <= 1'b1;
         scan_active <= 1'b0;
      end else begin
         write_strobe_lane0_out <= nxt_pin_out;
         write_strobe_lane0_oe_n <= nxt_pin_oe_n;
         core_strobe_in <= nxt_core_in;
         mirror_active <= nxt_mirror;
         ca_term_nominal <= nxt_ca_term;
         dq_term_on <= nxt_dq_term;
         scan_active <= nxt_active;
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);

   chk_idle_pin_passes: assert property (
      !in_scan |=> write_strobe_lane0_oe_n == $past(core_strobe_oe_n)
         && write_strobe_lane0_out == $past(core_strobe_out))
      else $error("normal strobe not passed through");
   chk_capture_first_pos: assert property (
      push_fire && op_ff == op_capture |-> st.push_data == pad_lvl[0]
         ##1 chain_ff == capture_image($past(pad_lvl)))
      else $error("capture did not present position 1");
   chk_shift_advance: assert property (
      push_fire && op_ff == op_shift |-> st.push_data == chain_ff[1])
      else $error("shift did not advance chain");
   chk_zero_fill: assert property (
      push_fire && op_ff == op_shift |=> chain_ff[66] == 1'b0)
      else $error("chain tail not filled with zero");
   chk_rsv_zero: assert property (
      push_fire && op_ff == op_capture |=> !chain_ff[`SCAN_RSV_IDX_A]
         && !chain_ff[`SCAN_RSV_IDX_B])
      else $error("reserved positions not zero");
   chk_mirror_off: assert property (
      in_scan |=> !mirror_active)
      else $error("mirroring active in scan mode");
   chk_term_scan: assert property (
      in_scan |=> ca_term_nominal && !dq_term_on)
      else $error("termination wrong in scan mode");
   chk_enter_scan: assert property (
      !in_scan && sen_lvl |=> in_scan ##1 scan_active)
      else $error("scan mode not entered");
   chk_out_enable: assert property (
      in_scan |=> write_strobe_lane0_oe_n == $past(soe_n_lvl))
      else $error("scan output enable not followed");
   chk_edge_taken: assert property (
      in_scan && sen_lvl && sck_rise |=> pend_ff
         && op_ff == ($past(ssh_lvl) ? op_shift : op_capture))
      else $error("scan clock edge lost");
   chk_serial_path: assert property (
      pop_fire |=> write_strobe_lane0_out == $past(st.pop_data))
      else $error("serial bit not driven");
endmodule // boundary_scan_test_mode

// ---- hw/scan_fifo.sv ----
`timescale 1ns/1ps
module scan_fifo #(
   parameter int WIDTH = 1,
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic reset_n,
   scan_stream_if.buffer st
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW-1:0] wr_ff, nxt_wr, rd_ff, nxt_rd;
   logic [AW:0] cnt_ff, nxt_cnt;
   logic do_push, do_pop;

   assign st.push_ready = (cnt_ff != DEPTH[AW:0]) && !st.flush;
   assign st.pop_valid = (cnt_ff != '0) && !st.flush;
   assign st.pop_data = mem_ff[rd_ff];
   assign do_push = st.push_valid && st.push_ready;
   assign do_pop = st.pop_valid && st.pop_ready;

   always_comb begin
      nxt_wr = wr_ff;
      nxt_rd = rd_ff;
      nxt_cnt = cnt_ff;
      if (st.flush) begin
         nxt_wr = '0;
         nxt_rd = '0;
         nxt_cnt = '0;
      end else begin
         if (do_push) nxt_wr = (wr_ff == AW'(DEPTH - 1)) ? '0 : wr_ff + 1'b1;
         if (do_pop) nxt_rd = (rd_ff == AW'(DEPTH - 1)) ? '0 : rd_ff + 1'b1;
         nxt_cnt = cnt_ff + (AW+1)'(do_push) - (AW+1)'(do_pop);
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wr_ff <= '0;
         rd_ff <= '0;
         cnt_ff <= '0;
      end else begin
         wr_ff <= nxt_wr;
         rd_ff <= nxt_rd;
         cnt_ff <= nxt_cnt;
      end
   end

   always_ff @(posedge clk) begin
      if (do_push) mem_ff[wr_ff] <= st.push_data;
   end
endmodule // scan_fifo

// ---- hw/scan_map.svh ----
// What this block does
// - Scan mode serialises pad levels on strobe pin
// - Enable low keeps pins in normal duty
// - 67 positions, position 1 shifted first
// - Zeros follow after position 67
// - Mirroring disabled during scan mode
// - Positions 56 and 57 read zero
// - Select low captures, high shifts
// - Scan clock pulses, rising edge only
// - Enable high enters, low leaves scan
// - Output enable low drives, high floats
// - Scan: nominal address termination, data off
`ifndef SCAN_MAP_SVH
`define SCAN_MAP_SVH
`define SCAN_CHAIN_LEN 67
`define SCAN_RSV_IDX_A 55
`define SCAN_RSV_IDX_B 56
`define SCAN_IN_SEN 0
`define SCAN_IN_SSH 1
`define SCAN_IN_SCK 2
`define SCAN_IN_SOE 3
`define SCAN_IN_MF 4
`define SCAN_IN_PAD 5
`define SCAN_SYNC_W 72
`define SCAN_FIFO_WIDTH 1
`define SCAN_FIFO_DEPTH 8
`endif

// ---- hw/scan_pkg.sv ----
package scan_pkg;
   typedef enum logic {st_normal, st_scan} mode_t;
   typedef enum logic {op_capture, op_shift} scan_op_t;
   typedef logic [66:0] chain_t;
endpackage

// ---- hw/scan_stream_if.sv ----
`timescale 1ns/1ps
interface scan_stream_if #(parameter int WIDTH = 1);
   logic flush;
   logic push_valid;
   logic push_ready;
   logic [WIDTH-1:0] push_data;
   logic pop_valid;
   logic pop_ready;
   logic [WIDTH-1:0] pop_data;
   modport producer (output flush, push_valid, push_data, pop_ready,
                     input push_ready, pop_valid, pop_data);
   modport buffer (input flush, push_valid, push_data, pop_ready,
                   output push_ready, pop_valid, pop_data);
endinterface

// ---- verification/scan_tester.sv ----
`timescale 1ns/1ps
module scan_tester (
   input wire logic clk,
   output logic scan_mode_enable,
   output logic scan_shift_select,
   output logic scan_clock,
   output logic scan_output_enable_n
);
   initial begin
      scan_mode_enable = 1'b0;
      scan_shift_select = 1'b0;
      scan_clock = 1'b0;
      scan_output_enable_n = 1'b1;
   end
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic set_mode(input logic en);
      scan_mode_enable = en;
      step(1);
   endtask
   // Driven to a hard level, never left to the strap
   task automatic set_oe_n(input logic v);
      scan_output_enable_n = v;
      step(1);
   endtask
   // Select settles in the low half; 100 ns low, 100 ns high
   task automatic pulse(input logic shift);
      scan_shift_select = shift;
      step(4);
      scan_clock = 1'b1;
      step(4);
      scan_clock = 1'b0;
   endtask
endmodule // scan_tester

// ---- verification/test_boundary_scan_test_mode.sv ----
`timescale 1ns/1ps
`define CHK(g, e) begin \
   total_checks++; \
   if ((g) !== (e)) begin \
      n_mismatch++; \
      $display("unexpected at %0t: got %b want %b", $time, g, e); \
   end \
end
module test_boundary_scan_test_mode
   import scan_pkg::*;
   ;
   logic clk, reset_n, mirror_function_pin, core_strobe_out, core_strobe_oe_n;
   chain_t pad_levels;
   logic scan_mode_enable, scan_shift_select, scan_clock, scan_output_enable_n;
   logic wsl_out, wsl_oe_n, core_strobe_in, mirror_active;
   logic ca_term_nominal, dq_term_on, scan_active, last_bit, exp_core;
   wire logic wsl_in;
   int n_mismatch = 0;
   int total_checks = 0;
   bit exp_q[$];
   // Released pin shows the inverse so a stale level cannot pass
   assign wsl_in = wsl_oe_n ? ~wsl_out : wsl_out;
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   scan_tester tester_u (.clk, .scan_mode_enable, .scan_shift_select, .scan_clock,
      .scan_output_enable_n);
   boundary_scan_test_mode dut_u (.clk, .reset_n, .pad_levels, .scan_mode_enable,
      .scan_shift_select, .scan_clock, .scan_output_enable_n, .mirror_function_pin,
      .core_strobe_out, .core_strobe_oe_n, .write_strobe_lane0_in(wsl_in),
      .write_strobe_lane0_out(wsl_out), .write_strobe_lane0_oe_n(wsl_oe_n),
      .core_strobe_in, .mirror_active, .ca_term_nominal, .dq_term_on, .scan_active);
   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wait_active(input logic v);
      for (int i = 0; i < 20 && scan_active !== v; i++) step(1);
      if (scan_active !== v) begin
         n_mismatch++;
         $display("unexpected at %0t: mode change timed out", $time);
         conclude();
      end
   endtask
   // Model chain: capture loads pads, reserved places read zero
   task automatic capture();
      exp_q = {};
      for (int i = 0; i < 67; i++)
         exp_q.push_back((i == 55 || i == 56) ? 1'b0 : pad_levels[i]);
   endtask
   function automatic logic next_bit();
      return exp_q.size() > 0 ? exp_q.pop_front() : 1'b0;
   endfunction
   // Pads change after each bit, so shifts must not resample
   task automatic scan_bit(input logic shift);
      if (!shift) capture();
      tester_u.pulse(shift);
      last_bit = next_bit();
      step(4);
      pad_levels = chain_t'({$urandom, $urandom, $urandom});
      mirror_function_pin = 1'($urandom);
   endtask
   initial begin
      int i;
      reset_n = 1'b0;
      pad_levels = '0;
      mirror_function_pin = 1'b0;
      core_strobe_out = 1'b0;
      core_strobe_oe_n = 1'b1;
      void'($urandom(32'h9487));
      repeat (12) @(posedge clk);
      #1;
      reset_n = 1'b1;
      step(2);
      for (i = 0; i < 8; i++) begin
         core_strobe_out = 1'($urandom);
         core_strobe_oe_n = 1'($urandom);
         mirror_function_pin = 1'($urandom);
         exp_core = wsl_in;
         step(1);
         `CHK(wsl_out, core_strobe_out)
         `CHK(wsl_oe_n, core_strobe_oe_n)
         `CHK(core_strobe_in, exp_core)
         // Output enable pin has no say outside scan mode
         tester_u.set_oe_n(1'($urandom));
         step(5);
         `CHK(mirror_active, mirror_function_pin)
         `CHK(wsl_oe_n, core_strobe_oe_n)
      end
      mirror_function_pin = 1'b1;
      step(6);
      `CHK(mirror_active, 1'b1)
      `CHK(dq_term_on, 1'b1)
      `CHK(scan_active, 1'b0)
      $display("normal mode test done");
      core_strobe_oe_n = 1'b1;
      tester_u.set_oe_n(1'b1);
      tester_u.set_mode(1'b1);
      wait_active(1'b1);
      `CHK(ca_term_nominal, 1'b1)
      `CHK(dq_term_on, 1'b0)
      `CHK(mirror_active, 1'b0)
      tester_u.set_oe_n(1'b0);
      pad_levels = chain_t'({$urandom, $urandom, $urandom});
      step(5);
      `CHK(wsl_oe_n, 1'b0)
      // Early random recaptures, then enough shifts to run past the tail
      for (i = 0; i < 90; i++) begin
         scan_bit(!(i == 0 || (i < 20 && $urandom_range(3) == 0)));
         `CHK(wsl_out, last_bit)
         `CHK(mirror_active, 1'b0)
      end
      $display("capture and shift test done");
      tester_u.set_oe_n(1'b1);
      step(5);
      `CHK(wsl_oe_n, 1'b1)
      capture();
      tester_u.pulse(1'b0);
      // Eight bits fill the buffer, the ninth edge must wait
      for (i = 0; i < 8; i++) tester_u.pulse(1'b1);
      for (i = 0; i < 9; i++) last_bit = next_bit();
      tester_u.set_oe_n(1'b0);
      step(16);
      `CHK(wsl_out, last_bit)
      scan_bit(1'b1);
      `CHK(wsl_out, last_bit)
      $display("stalled output test done");
      tester_u.set_mode(1'b0);
      wait_active(1'b0);
      `CHK(dq_term_on, 1'b1)
      `CHK(ca_term_nominal, 1'b0)
      core_strobe_out = 1'b1;
      core_strobe_oe_n = 1'b0;
      step(1);
      `CHK(wsl_out, 1'b1)
      `CHK(wsl_oe_n, 1'b0)
      $display("scan exit test done");
      conclude();
   end
endmodule // test_boundary_scan_test_mode
